// ==== qsas_seq.sv ====
`timescale 1ns/1ps
// Four-channel simultaneous-sampling converter sequencer and read port
module qsas_seq #(
	parameter int unsigned CLK_DIV      = qsas_pkg::CLK_DIV,
	parameter int unsigned SETTLE_TICKS = qsas_pkg::SETTLE_TICKS
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        sample_trigger_n, // Async start, rising edge acts
	input  wire logic        cs_n,             // Chip select pin
	input  wire logic        rd_n,             // Read strobe pin
	input  wire logic        comp_above,       // Analog comparator result
	output logic             hold,             // All track/holds in hold
	output logic [1:0]       mux_sel,          // Channel at the converter
	output logic [11:0]      dac_code,         // DAC trial code
	output logic             complete_n,       // Results ready, active low
	output logic [11:0]      data_out,         // Read data
	output logic             data_oe           // Read data driven
);
	localparam int unsigned DIV_W = $clog2(CLK_DIV);            // Divider width
	localparam int unsigned SEQ_T =
		qsas_pkg::START_TICKS + qsas_pkg::NUM_CH *
		(SETTLE_TICKS + qsas_pkg::RES_BITS + qsas_pkg::STORE_TICKS); // Edges per sequence

	// The first bit spends one clock on the start pulse, one loading the trial code and two
	// more in the comparator synchroniser, so a tick needs four clocks at least.
	// Settle count lives in a four-bit counter and must be at least one.
	// Refuse settings the timing limit or the divider cannot serve;
	// below four clocks a tick the comparator answer would arrive late
	if (CLK_DIV < 4 || SETTLE_TICKS < 1 || SETTLE_TICKS > 15 ||
		SEQ_T + 1 > qsas_pkg::CONV_MAX_TICKS) begin : g_chk
		$error("qsas_seq: divider or settle count out of range");
	end

	typedef enum logic [2:0] {
		QSAS_IDLE,
		QSAS_START,
		QSAS_SETTLE,
		QSAS_CONV,
		QSAS_STORE
	} qsas_phase_t;

	typedef struct packed {
		logic                   trig_s1, trig_s2, trig_s3; // Start synchroniser, edge
		logic                   cs_s1, cs_s2, cs_s3;       // Select synchroniser
		logic                   rd_s1, rd_s2, rd_s3;       // Strobe synchroniser
		logic                   comp_s1, comp_s2;          // Comparator synchroniser
		logic [DIV_W-1:0]       div_cnt;                   // Conversion clock divider
		logic                   tick;                      // Conversion clock enable
		qsas_phase_t            phase;                     // Sequencer phase
		logic [3:0]             cnt;                       // Ticks within a phase
		logic [1:0]             chan;                      // Channel being converted
		logic                   sar_start;                 // Engine start pulse
		logic [3:0][11:0]       results;                   // Result registers
		logic [1:0]             ptr;                       // Implicit read pointer
		logic                   hold;                      // Track/hold control
		logic                   complete_n;                // Completion flag
		logic [11:0]            data_out;                  // Read data
		logic                   data_oe;                   // Read data enable
	} qsas_state_t;

	qsas_state_t s_reg;  // Registered state
	qsas_state_t s_next; // Next state
	qsas_sar_if  sar_bus ();

	logic trig_rise; // Start edge seen
	logic rd_fall;   // Strobe fell while selected
	logic rd_rise;   // Selected read completed

	qsas_sar u_sar (
		.clk    (clk),
		.resetn (resetn),
		.bus    (sar_bus)
	);

	// Edge detectors look only at second and third stages
	// First stages may still be settling, so nothing else reads them;
	// the third stage only adds a delayed copy for edge finding
	assign trig_rise = s_reg.trig_s2 && !s_reg.trig_s3;
	assign rd_fall   = !s_reg.rd_s2 && s_reg.rd_s3 && !s_reg.cs_s2;
	assign rd_rise   = s_reg.rd_s2 && !s_reg.rd_s3 && !s_reg.cs_s3;

	// Sequencer, result store and read port
	always_comb begin
		s_next           = s_reg;
		s_next.sar_start = 1'b0;
		// Pins cross two flops before any logic
		// Comparator gets no third stage: only its level matters,
		// and the divider leaves room for the two-clock lag
		s_next.trig_s1   = sample_trigger_n;
		s_next.trig_s2   = s_reg.trig_s1;
		s_next.trig_s3   = s_reg.trig_s2;
		s_next.cs_s1     = cs_n;
		s_next.cs_s2     = s_reg.cs_s1;
		s_next.cs_s3     = s_reg.cs_s2;
		s_next.rd_s1     = rd_n;
		s_next.rd_s2     = s_reg.rd_s1;
		s_next.rd_s3     = s_reg.rd_s2;
		s_next.comp_s1   = comp_above;
		s_next.comp_s2   = s_reg.comp_s1;
		// Free-running divider; the start edge lands anywhere in a tick,
		// hence one edge of spread in the sequence length
		// Divider runs while idle too, so a start never waits for it
		s_next.tick      = (s_reg.div_cnt == DIV_W'(CLK_DIV - 1));
		s_next.div_cnt   = s_next.tick ? '0 : s_reg.div_cnt + DIV_W'(1);

		unique case (s_reg.phase)
			QSAS_IDLE: begin
				if (trig_rise) begin
					s_next.hold  = 1'b1;
					s_next.phase = QSAS_START;
					s_next.cnt   = 4'h0;
					s_next.chan  = 2'h0;
				end
				// A new sample makes the old results stale, so the flag goes high
				if (trig_rise) begin
					s_next.complete_n = 1'b1;
				end
				// Reads are served only between sequences
				if (rd_fall) begin
					s_next.complete_n = 1'b1;
				end
				if (rd_rise) begin
					s_next.ptr = s_reg.ptr + 2'h1;
				end
			end
			QSAS_START: begin
				if (s_reg.tick) begin
					if (s_reg.cnt == 4'(qsas_pkg::START_TICKS - 1)) begin
						s_next.phase = QSAS_SETTLE;
						s_next.cnt   = 4'h0;
					end else begin
						s_next.cnt = s_reg.cnt + 4'h1;
					end
				end
			end
			QSAS_SETTLE: begin
				if (s_reg.tick) begin
					if (s_reg.cnt == 4'(SETTLE_TICKS - 1)) begin
						s_next.phase     = QSAS_CONV;
						s_next.sar_start = 1'b1;
					end else begin
						s_next.cnt = s_reg.cnt + 4'h1;
					end
				end
			end
			QSAS_CONV: begin
				// Engine spends one tick per bit
				// Done comes one clock after the last tick, long before the next
				if (sar_sar_done()) begin
					s_next.results[s_reg.chan] = sar_bus.trial ^ qsas_pkg::SIGN_FLIP;
					s_next.phase               = QSAS_STORE;
				end
			end
			QSAS_STORE: begin
				if (s_reg.tick) begin
					s_next.cnt = 4'h0;
					if (s_reg.chan == 2'(qsas_pkg::NUM_CH - 1)) begin
						s_next.phase      = QSAS_IDLE;
						s_next.hold       = 1'b0;
						s_next.complete_n = 1'b0;
					end else begin
						s_next.chan  = s_reg.chan + 2'h1;
						s_next.phase = QSAS_SETTLE;
					end
				end
			end
		endcase

		// Start edge always rewinds the pointer; placed last so it wins
		// over a selected read that completes in the same cycle
		if (trig_rise) begin
			s_next.ptr = qsas_pkg::PTR_RESET;
		end

		// Enable follows the pins with three clocks of lag; a host that
		// reads across a start edge may overlap hold for one cycle
		// Data only through the pointer, never by address
		s_next.data_oe  = (s_reg.phase == QSAS_IDLE) && !s_reg.cs_s2 && !s_reg.rd_s2;
		s_next.data_out = s_next.data_oe ? s_reg.results[s_reg.ptr] : 12'h000;
	end

	// Wrapper keeps the engine handshake in one place
	function automatic logic sar_sar_done();
		return sar_bus.done;
	endfunction : sar_sar_done

	// State register
	// Trigger, select and strobe synchroniser stages reset high, the idle level of those pins,
	// so no false trigger or strobe edge follows reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg            <= '0;
			s_reg.trig_s1    <= 1'b1;
			s_reg.trig_s2    <= 1'b1;
			s_reg.trig_s3    <= 1'b1;
			s_reg.cs_s1      <= 1'b1;
			s_reg.cs_s2      <= 1'b1;
			s_reg.cs_s3      <= 1'b1;
			s_reg.rd_s1      <= 1'b1;
			s_reg.rd_s2      <= 1'b1;
			s_reg.rd_s3      <= 1'b1;
			s_reg.phase      <= QSAS_IDLE;
			s_reg.ptr        <= qsas_pkg::PTR_RESET;
			s_reg.complete_n <= qsas_pkg::COMPLETE_N_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// Engine hookup
	assign sar_bus.start      = s_reg.sar_start;
	assign sar_bus.tick       = s_reg.tick;
	assign sar_bus.comp_above = s_reg.comp_s2;

	// Outputs straight from flops
	// Trial code comes from the engine's own register, not from logic
	// Data bus stays at zero whenever it is not enabled
	assign hold       = s_reg.hold;
	assign mux_sel    = s_reg.chan;
	assign dac_code   = sar_bus.trial;
	assign complete_n = s_reg.complete_n;
	assign data_out   = s_reg.data_out;
	assign data_oe    = s_reg.data_oe;
endmodule : qsas_seq

// ==== qsas_pkg.sv ====
package qsas_pkg;
	localparam int unsigned CLK_HZ           = 100_000_000; // System clock
	localparam int unsigned CLK_PERIOD_NS    = 10;          // System clock period
	localparam int unsigned CONV_CLK_HZ      = 2_500_000;   // Conversion clock rate
	localparam int unsigned CLK_DIV          = CLK_HZ / CONV_CLK_HZ; // Cycles per tick
	localparam int unsigned RES_BITS         = 12;          // Result width
	localparam int unsigned NUM_CH           = 4;           // Channels per sequence
	localparam int unsigned START_TICKS      = 2;           // Wake-up before channel 1
	localparam int unsigned SETTLE_TICKS     = 6;           // Mux settle per channel
	localparam int unsigned STORE_TICKS      = 1;           // Result store per channel
	localparam int unsigned SEQ_TICKS        =
		START_TICKS + NUM_CH * (SETTLE_TICKS + RES_BITS + STORE_TICKS); // 78 edges
	localparam int unsigned CONV_TIME_MAX_NS = 32500;       // Start to completion limit
	localparam int unsigned CONV_MAX_TICKS   =
		CONV_TIME_MAX_NS / (CLK_PERIOD_NS * CLK_DIV);       // Rounded down
	localparam logic [11:0] SAR_MID          = 12'h800;     // First trial code
	localparam logic [11:0] SIGN_FLIP        = 12'h800;     // Offset binary to two's compl.
	localparam logic [1:0]  PTR_RESET        = 2'h0;        // Pointer at channel 1
	localparam logic        COMPLETE_N_RESET = 1'b1;        // Completion flag idle high
endpackage : qsas_pkg

// ==== qsas_sar_if.sv ====
`timescale 1ns/1ps
// Sequencer to approximation engine link
interface qsas_sar_if;
	logic        start;      // One-cycle pulse, begin a 12-bit search
	logic        tick;       // Conversion clock enable
	logic        comp_above; // Synchronised comparator: input above trial
	logic        done;       // One-cycle pulse, search finished
	logic [11:0] trial;      // Trial code, final code after done

	modport seq (output start, output tick, output comp_above, input done, input trial);
	modport sar (input start, input tick, input comp_above, output done, output trial);
endinterface : qsas_sar_if

// ==== qsas_sar.sv ====
`timescale 1ns/1ps
// Successive approximation engine, one bit decided per conversion tick
module qsas_sar (
	input  wire logic clk,
	input  wire logic resetn,
	qsas_sar_if.sar   bus
);
	typedef struct packed {
		logic [11:0] trial;   // Working code, drives the DAC
		logic [3:0]  bit_idx; // Bit under test
		logic        busy;    // Search running
		logic        done;    // Finished pulse
	} qsas_sar_state_t;

	qsas_sar_state_t s_reg;  // Registered state
	qsas_sar_state_t s_next; // Next state

	// Bit decisions; MSB first so the code is offset binary
	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		if (bus.start) begin
			s_next.trial   = qsas_pkg::SAR_MID;
			s_next.bit_idx = 4'hB;
			s_next.busy    = 1'b1;
		end else if (bus.tick && s_reg.busy) begin
			// Drop the trial bit when the input sits below it
			if (!bus.comp_above) begin
				s_next.trial[s_reg.bit_idx] = 1'b0;
			end
			if (s_reg.bit_idx == 4'h0) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end else begin
				s_next.trial[s_reg.bit_idx - 4'h1] = 1'b1;
				s_next.bit_idx                     = s_reg.bit_idx - 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus.trial = s_reg.trial;
	assign bus.done  = s_reg.done;
endmodule : qsas_sar

// ==== qsas_seq_assertions.sv ====
`timescale 1ns/1ps
// Pin-level timing checks on the sequencer
module qsas_seq_assertions #(
	parameter int unsigned CLK_DIV = qsas_pkg::CLK_DIV
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        sample_trigger_n,
	input wire logic        cs_n,
	input wire logic        rd_n,
	input wire logic        hold,
	input wire logic [1:0]  mux_sel,
	input wire logic        complete_n,
	input wire logic [11:0] data_out,
	input wire logic        data_oe
);
	int unsigned cnt_reg; // Cycles spent holding
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Count hold cycles, cleared while tracking
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 0;
		end else begin
			cnt_reg <= hold ? cnt_reg + 1 : 0;
		end
	end
	property p_start;
		$rose(sample_trigger_n) && !hold |-> ##[1:5] hold;
	endproperty
	a_start: assert property (p_start) else $error("trigger edge ignored");
	property p_span;
		$fell(hold) |-> cnt_reg >= 77 * CLK_DIV && cnt_reg <= 79 * CLK_DIV;
	endproperty
	a_span: assert property (p_span) else $error("sequence length off");
	property p_limit;
		$fell(hold) |-> cnt_reg <= qsas_pkg::CONV_MAX_TICKS * CLK_DIV;
	endproperty
	a_limit: assert property (p_limit) else $error("sequence too slow");
	property p_done;
		$fell(complete_n) |-> $fell(hold);
	endproperty
	a_done: assert property (p_done) else $error("completion early");
	property p_order;
		hold && $changed(mux_sel) |-> mux_sel == $past(mux_sel) + 2'h1;
	endproperty
	a_order: assert property (p_order) else $error("channel order broken");
	property p_release;
		$fell(rd_n) && !cs_n && !complete_n && !hold |-> ##[1:5] complete_n;
	endproperty
	a_release: assert property (p_release) else $error("completion kept");
	property p_quiet;
		hold |-> !data_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus driven in sequence");
	property p_drive;
		(!rd_n && !cs_n && !hold)[*5] |-> data_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("read not driven");
	property p_float;
		!data_oe |-> data_out == 12'h000;
	endproperty
	a_float: assert property (p_float) else $error("data without enable");
endmodule : qsas_seq_assertions

bind qsas_seq qsas_seq_assertions #(.CLK_DIV(CLK_DIV)) u_chk (.clk(clk), .resetn(resetn),
	.sample_trigger_n(sample_trigger_n), .cs_n(cs_n), .rd_n(rd_n), .hold(hold),
	.mux_sel(mux_sel), .complete_n(complete_n), .data_out(data_out), .data_oe(data_oe));

// ==== qsas_afe_model.sv ====
`timescale 1ns/1ps
// Analog side: four track/holds, channel mux and comparator
module qsas_afe_model (
	input  wire logic        clk,
	input  wire logic        hold,
	input  wire logic [1:0]  mux_sel,
	input  wire logic [11:0] dac_code,
	input  wire logic [47:0] vin,       // Channel codes, channel 1 lowest
	output logic             comp_above
);
	logic [47:0] held;            // Frozen samples
	logic        idle_reg = 1'b0; // Junk level outside a sequence
	logic [11:0] ob;              // Held code as offset binary
	// All four freeze together on the hold edge
	always @(posedge hold) held = vin;
	always @(posedge clk) idle_reg <= ~idle_reg;
	assign ob = held[mux_sel * 12 +: 12] ^ 12'h800;
	// Input sits half a step above its code, so ties go upward
	assign comp_above = hold ? (ob >= dac_code) : idle_reg;
endmodule : qsas_afe_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned DIV = 8; // Short tick keeps the run brief
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        trig_n = 1'b1;
	logic        cs_n = 1'b1;
	logic        rd_n = 1'b1;
	logic        comp_above, hold, complete_n, data_oe;
	logic [1:0]  mux_sel;
	logic [11:0] dac_code, data_out;
	logic [47:0] vin = '0; // Channel codes, channel 1 lowest
	int          failures = 0;
	int          checks = 0;
	always #5 clk = ~clk;
	qsas_seq #(.CLK_DIV(DIV)) uut (.clk(clk), .resetn(resetn), .sample_trigger_n(trig_n),
		.cs_n(cs_n), .rd_n(rd_n), .comp_above(comp_above), .hold(hold), .mux_sel(mux_sel),
		.dac_code(dac_code), .complete_n(complete_n), .data_out(data_out), .data_oe(data_oe));
	qsas_afe_model afe (.clk(clk), .hold(hold), .mux_sel(mux_sel), .dac_code(dac_code),
		.vin(vin), .comp_above(comp_above));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	// One read strobe, held long enough for the pin synchronisers
	task automatic rd(input logic sel_n, input logic [11:0] exp);
		cs_n = sel_n;
		rd_n = 1'b0;
		step(5);
		cmp({11'h0, data_oe}, {11'h0, ~sel_n});
		cmp(data_out, exp);
		rd_n = 1'b1;
		cs_n = 1'b1;
		step(5);
	endtask : rd
	// Trigger pulse, then spoil the inputs once holding
	task automatic convert(input logic [47:0] codes);
		int n;
		vin = codes;
		trig_n = 1'b0;
		step(3);
		trig_n = 1'b1;
		n = 0;
		step(6);
		vin = ~codes;
		cmp({11'h0, complete_n}, 12'h001);
		// Wait for completion before any retrigger or read
		while (complete_n !== 1'b0 && n < 2000) begin
			step(1);
			n++;
		end
		if (n >= 2000) begin
			failures++;
			stop_test();
		end
		cmp({11'h0, n + 6 <= 79 * DIV + 4}, 12'h001);
		cmp({11'h0, n + 6 >= 77 * DIV}, 12'h001);
		cmp({11'h0, hold}, 12'h000);
		cmp({10'h0, mux_sel}, 12'h003);
	endtask : convert
	task automatic t_bounds;
		convert({12'h801, 12'h800, 12'h7FE, 12'h7FF});
		rd(1'b0, 12'h7FF);
		cmp({11'h0, complete_n}, 12'h001);
		rd(1'b0, 12'h7FE);
		rd(1'b0, 12'h800);
		rd(1'b0, 12'h801);
		rd(1'b0, 12'h7FF);
		$display("test bounds done");
	endtask : t_bounds
	task automatic t_zero;
		convert({12'hABC, 12'h123, 12'h000, 12'hFFF});
		rd(1'b1, 12'h000);
		rd(1'b0, 12'hFFF);
		rd(1'b0, 12'h000);
		convert({12'h3C3, 12'h3C3, 12'h3C3, 12'h3C3});
		convert({12'h555, 12'h2AA, 12'h001, 12'h456});
		rd(1'b0, 12'h456);
		rd(1'b0, 12'h001);
		rd(1'b0, 12'h2AA);
		rd(1'b0, 12'h555);
		$display("test zero done");
	endtask : t_zero
	initial begin
		step(16);
		resetn = 1'b1;
		step(2);
		t_bounds();
		t_zero();
		stop_test();
	end
endmodule : tb_top
